// ===== pap_access_timer.sv
// wait-state timer between the internal bus and the peripheral regions
//
// Operation
// R1: controller range takes 2 system cycles for reads and writes.
// R2: cpu/debug/cache range reads take 4, writes 3 system cycles.
// R3: lower system control range reads take 5, writes 4 system cycles.
// R4: upper system control range timed in slow clock, 9/8 equal, up to 8 faster.
// R5: port range slow clock, 5 read 4 write, faster 2-5 and 2-4.
// R6: event/clock/watchdog range slow clock, 5/4, faster 3-5 and 2-4.
// R7: first serial bus device range slow clock, 6/5, faster 3-6 and 3-5.
// R8: second serial bus device range slow clock, 4/3, faster 1-4 and 1-3.
// R9: low-power timer range slow clock, 7 read 4 write, faster reads 5-7.
// R10: pwm timer range fast clock, 7 read 4 write, faster reads 4-7.
// R11: crypto range fast clock, 6 read 4 write, faster reads 3-6.
// R12: converter range fast clock, 5 read 4 write, faster 2-5 and 2-4.
// R13: flash link data reads at least 25, writes at least 6 or 5.
// R14: flash link control writes at least 14, reads 5 fast cycles.
// R15: flash link misc register 4 read 3 write, faster 1-4 and 1-3.
// R16: data flash range timed in flash clock, 3 each, faster 2-3.
// R17: fractional unit counts: lower bound truncated, upper bound rounded up.
// R18: sixteen-bit serial interface register accesses add 2 cycles.
// R19: 32-bit serial peripheral data access adds 2 cycles.
// R20: open-ended flash link counts stretch with the link's bus cycles.
// R21: faster system clock adds at least one peripheral cycle of sync.
// R22: masters must not touch reserved addresses; no guarantee there.
// R23: write counts are for non-bufferable writes, requester waits.
// R24: completion acknowledge held until selected count elapses in its clock.
// R25: ratio set chosen from static clock ratio configuration inputs.
`timescale 1ns/10ps
module pap_access_timer (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_size,
  input  wire logic [3:0]  fast_periph_div,
  input  wire logic [3:0]  slow_periph_div,
  input  wire logic [3:0]  flash_div,
  input  wire logic        qspi_busy,
  output logic             req_ready,
  output logic             ack,
  output logic             err
);

  typedef enum logic [0:0] {
    PAP_IDLE = 1'b0,
    PAP_WAIT = 1'b1
  } pap_state_t;

  pap_state_t  state;
  pap_state_t  next_state;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [1:0]  cur_unit;
  logic [1:0]  next_cur_unit;
  logic        cur_open;
  logic        next_cur_open;
  logic        cur_err;
  logic        next_cur_err;
  logic        next_ack;
  logic        next_err;
  logic        next_req_ready;

  logic [3:0]  div_cfg [3];
  logic [2:0]  unit_ce;
  logic        hit;
  logic [4:0]  idx;
  logic [3:0]  sel_div;
  logic        fast_ratio;
  logic [5:0]  need;
  logic        open_end;
  logic        cur_ce;

  assign div_cfg[0] = fast_periph_div;
  assign div_cfg[1] = slow_periph_div;
  assign div_cfg[2] = flash_div;

  // one enable per divided clock; the system clock needs none
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_div
      pap_ce_div u_div (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .div     (div_cfg[g]),
        .ce      (unit_ce[g])
      );
    end
  endgenerate

  // enable of a given cycle unit
  function automatic logic unit_enable(input logic [1:0] unit, input logic [2:0] ces);
    unit_enable = (unit == pap_pkg::PAP_UNIT_SYS) ? 1'b1 : ces[unit - 2'h1];
  endfunction

  // lowest index wins where ranges overlap
  function automatic logic [5:0] region_of(input logic [31:0] addr);
    region_of = 6'h00;
    for (int i = pap_pkg::PAP_NREG - 1; i >= 0; i--) begin
      if (addr >= pap_pkg::PAP_LO[i] && addr <= pap_pkg::PAP_HI[i]) begin
        region_of = {1'b1, 5'(i)};
      end
    end
  endfunction

  always_comb begin
    {hit, idx} = region_of(req_addr);
    case (pap_pkg::PAP_UNIT[idx])
      pap_pkg::PAP_UNIT_FAST:  sel_div = fast_periph_div;
      pap_pkg::PAP_UNIT_SLOW:  sel_div = slow_periph_div;
      pap_pkg::PAP_UNIT_FLASH: sel_div = flash_div;
      default:                 sel_div = pap_pkg::PAP_DIV_EQUAL;
    endcase
    // static ratio picks equal or faster-system count set
    fast_ratio = (sel_div > pap_pkg::PAP_DIV_EQUAL); // R25
    if (req_write) begin
      need = {1'b0, fast_ratio ? pap_pkg::PAP_WR_FAST[idx] : pap_pkg::PAP_WR_EQ[idx]}; // R23
      open_end = pap_pkg::PAP_WR_OPEN[idx];
    end else begin
      need = {1'b0, fast_ratio ? pap_pkg::PAP_RD_FAST[idx] : pap_pkg::PAP_RD_EQ[idx]};
      open_end = pap_pkg::PAP_RD_OPEN[idx];
    end
    // wide serial registers carry a surcharge in the unit clock
    if (idx == pap_pkg::PAP_IDX_SERIAL_IF && req_size == pap_pkg::PAP_SIZE_HALF) begin
      need = 6'(need + pap_pkg::PAP_WIDE_EXTRA); // R18
    end
    if (idx == pap_pkg::PAP_IDX_SERIAL_PER && req_size == pap_pkg::PAP_SIZE_WORD) begin
      need = 6'(need + pap_pkg::PAP_WIDE_EXTRA); // R19
    end
    if (!hit) begin
      need = pap_pkg::PAP_UNMAPPED_CYC;
      open_end = 1'b0;
    end
    cur_ce = unit_enable(cur_unit, unit_ce);
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur_unit = cur_unit;
    next_cur_open = cur_open;
    next_cur_err = cur_err;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_req_ready = req_ready;
    case (state)
      PAP_IDLE: begin
        if (req_valid) begin
          next_state = PAP_WAIT;
          next_cnt = need; // R9 R10 R11 R12 R15 R16
          // unmapped accesses are timed as system cycles and flagged
          next_cur_unit = hit ? pap_pkg::PAP_UNIT[idx] : pap_pkg::PAP_UNIT_SYS;
          next_cur_open = open_end;
          next_cur_err = !hit;
          next_req_ready = 1'b0;
        end
      end
      PAP_WAIT: begin
        // whole unit edges only: bounds land on integer counts
        if (cur_ce) begin // R17 R21
          if (cnt == 6'h01) begin
            // minimum reached; open counts also wait for the link
            if (!(cur_open && qspi_busy)) begin // R20 R13 R14
              next_state = PAP_IDLE;
              next_ack = 1'b1; // R24
              next_err = cur_err;
              next_req_ready = 1'b1;
            end
          end else begin
            next_cnt = 6'(cnt - 6'h01); // R1 R2 R3 R4 R5 R6 R7 R8
          end
        end
      end
      default: begin
        next_state = PAP_IDLE;
        next_req_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= PAP_IDLE;
      cnt <= 6'h00;
      cur_unit <= pap_pkg::PAP_UNIT_SYS;
      cur_open <= 1'b0;
      cur_err <= 1'b0;
      ack <= 1'b0;
      err <= 1'b0;
      req_ready <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur_unit <= next_cur_unit;
      cur_open <= next_cur_open;
      cur_err <= next_cur_err;
      ack <= next_ack;
      err <= next_err;
      req_ready <= next_req_ready;
    end
  end

  // helper state watched only by the checks below
  logic [15:0] lat;
  logic [4:0]  a_idx;
  logic        a_wr;
  logic        a_fast;
  logic [5:0]  a_need;
  logic [3:0]  a_div;
  logic        a_hit;
  logic        a_half;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lat <= 16'h0000;
      a_idx <= 5'h00;
      a_wr <= 1'b0;
      a_fast <= 1'b0;
      a_need <= 6'h00;
      a_div <= 4'h1;
      a_hit <= 1'b0;
      a_half <= 1'b0;
    end else if (state == PAP_IDLE && req_valid) begin
      lat <= 16'h0000;
      a_idx <= idx;
      a_wr <= req_write;
      a_fast <= fast_ratio;
      a_need <= need;
      a_div <= (sel_div == 4'h0) ? 4'h1 : sel_div;
      a_hit <= hit;
      a_half <= (req_size == pap_pkg::PAP_SIZE_HALF);
    end else if (state == PAP_WAIT) begin
      lat <= 16'(lat + 16'h0001);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_ctrl_two;
    ack && a_hit && a_idx == 5'h00 |-> lat == 16'h0002;
  endproperty
  a_ctrl_two: assert property (p_ctrl_two) else $error("controller range not 2 cycles"); // R1

  property p_cpu_range;
    ack && a_hit && a_idx == 5'h01 |-> lat == (a_wr ? 16'h0003 : 16'h0004);
  endproperty
  a_cpu_range: assert property (p_cpu_range) else $error("cpu range count wrong"); // R2

  property p_sys_lo;
    ack && a_hit && a_idx == 5'h02 |-> lat == (a_wr ? 16'h0004 : 16'h0005);
  endproperty
  a_sys_lo: assert property (p_sys_lo) else $error("lower system range count wrong"); // R3

  property p_sys_hi_equal;
    ack && a_hit && a_idx == 5'h03 && !a_fast |-> lat == (a_wr ? 16'h0008 : 16'h0009);
  endproperty
  a_sys_hi_equal: assert property (p_sys_hi_equal) else $error("upper system range wrong"); // R4

  property p_flash_equal;
    ack && a_hit && a_idx == 5'h18 && !a_fast |-> lat == 16'h0003;
  endproperty
  a_flash_equal: assert property (p_flash_equal) else $error("data flash count wrong"); // R16

  property p_qspi_data_min;
    ack && a_hit && a_idx == 5'h15 && !a_wr |-> lat > 16'(16'h0018 * a_div);
  endproperty
  a_qspi_data_min: assert property (p_qspi_data_min) else $error("flash data read short"); // R13

  property p_open_waits_link;
    ack && a_hit && (a_idx == 5'h14 || a_idx == 5'h16) && a_wr |-> !$past(qspi_busy)
      && lat >= 16'h000E;
  endproperty
  a_open_waits_link: assert property (p_open_waits_link) else $error("open write early"); // R20

  property p_sync_floor;
    ack && a_fast |-> lat >= 16'(a_div) && lat > 16'(16'(a_need - 6'h01) * a_div);
  endproperty
  a_sync_floor: assert property (p_sync_floor) else $error("faster ratio count too low"); // R21

  property p_round_up;
    ack && a_fast && !(a_idx >= 5'h14 && a_idx <= 5'h16) |-> lat <= 16'(a_need * a_div);
  endproperty
  a_round_up: assert property (p_round_up) else $error("faster ratio count too high"); // R17

  property p_serial_half;
    ack && a_hit && a_idx == 5'h0F && !a_fast && a_half
      |-> lat == (a_wr ? 16'h0006 : 16'h0007);
  endproperty
  a_serial_half: assert property (p_serial_half) else $error("serial halfword surcharge"); // R18

  property p_ack_ends_wait;
    ack |-> $past(state) == PAP_WAIT && state == PAP_IDLE && req_ready;
  endproperty
  a_ack_ends_wait: assert property (p_ack_ends_wait) else $error("ack outside a wait"); // R24

  c_ctrl: cover property (ack && a_hit && a_idx == 5'h00);
  c_qspi_stall: cover property (state == PAP_WAIT && cur_open && qspi_busy ##1 ack);
  c_unmapped: cover property (err);
  c_slow_fast: cover property (ack && a_fast && a_idx == 5'h04);

endmodule

// ===== pap_access_timer_test.sv
// self-checking bench for the peripheral access wait-state timer
`timescale 1ns/10ps
module pap_access_timer_test;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic        req_write = 1'b0;
  logic [1:0]  req_size = 2'h2;
  logic [3:0]  fast_periph_div = 4'h1;
  logic [3:0]  slow_periph_div = 4'h1;
  logic [3:0]  flash_div = 4'h1;
  logic [7:0]  busy_len = 8'h00;
  logic        qspi_busy;
  logic        req_ready;
  logic        ack;
  logic        err;
  int          miscompares = 0;
  int          n_compared = 0;

  always #20 clk_sys = ~clk_sys;

  pap_access_timer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_size(req_size),
    .fast_periph_div(fast_periph_div), .slow_periph_div(slow_periph_div),
    .flash_div(flash_div), .qspi_busy(qspi_busy), .req_ready(req_ready), .ack(ack), .err(err));

  pap_qspi_link u_link (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .busy_len(busy_len), .qspi_busy(qspi_busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // one access, entered just after an edge; n counts cycles from taking edge to ack
  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] s,
                        output int n, output logic e);
    check(req_ready, 1'b1, "ready before request");
    req_addr = a;
    req_write = w;
    req_size = s;
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    n = 0;
    e = 1'b0;
    while (n < 400) begin
      if (n == 0) check(req_ready, 1'b0, "ready held low while busy");
      @(posedge clk_sys);
      #1;
      n++;
      if (ack === 1'b1) begin
        e = err;
        break;
      end
    end
  endtask

  task automatic exact(input logic [31:0] a, input logic w, input logic [1:0] s, input int cyc);
    int   n;
    logic e;
    access(a, w, s, n, e);
    check(n, cyc, "cycle count");
    check(e, 1'b0, "no error");
  endtask

  task automatic pair(input logic [31:0] a, input int rd, input int wr);
    exact(a, 1'b0, 2'h2, rd);
    exact(a, 1'b1, 2'h2, wr);
  endtask

  // faster system clock: count of n unit cycles, unit phase at take not counted
  task automatic ranged(input logic [31:0] a, input logic w, input int cyc, input int d);
    int   n;
    logic e;
    access(a, w, 2'h2, n, e);
    check((n >= (cyc - 1) * d + 1) && (n <= cyc * d), 1'b1, "ranged count");
    check(e, 1'b0, "no error");
  endtask

  task automatic t_reset;
    repeat (2) @(posedge clk_sys);
    #1;
    check({req_ready, ack, err}, 3'b100, "outputs in reset");
    repeat (14) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    $display("test reset done");
  endtask

  task automatic t_equal;
    pair(32'h4000_0000, 2, 2);
    pair(32'h4000_6FFF, 2, 2);
    pair(32'h4001_CFFF, 4, 3);
    pair(32'h4001_E000, 5, 4);
    pair(32'h4001_E400, 9, 8);
    pair(32'h4008_0000, 5, 4);
    pair(32'h4008_3FFF, 5, 4);
    pair(32'h4009_3FFF, 6, 5);
    pair(32'h4009_4000, 4, 3);
    pair(32'h400E_8000, 7, 4);
    pair(32'h4016_9000, 7, 4);
    pair(32'h4016_1000, 6, 4);
    pair(32'h4017_2FFF, 5, 4);
    pair(32'h6400_0010, 25, 6);
    pair(32'h6400_0000, 5, 14);
    pair(32'h6400_0037, 5, 14);
    pair(32'h6400_0807, 4, 3);
    pair(32'h407F_C000, 3, 3);
    $display("test equal clocks done");
  endtask

  task automatic t_faster;
    slow_periph_div = 4'h2;
    fast_periph_div = 4'h3;
    flash_div = 4'h2;
    repeat (4) @(posedge clk_sys);
    #1;
    pair(32'h4000_0000, 2, 2);
    ranged(32'h4001_E400, 1'b0, 8, 2);
    ranged(32'h4008_0000, 1'b0, 5, 2);
    ranged(32'h4009_4FFF, 1'b1, 3, 2);
    ranged(32'h4016_9000, 1'b0, 7, 3);
    ranged(32'h6400_0804, 1'b0, 4, 3);
    ranged(32'h6400_0010, 1'b1, 5, 3);
    ranged(32'h407F_EFFF, 1'b1, 3, 2);
    slow_periph_div = 4'h1;
    fast_periph_div = 4'h1;
    flash_div = 4'h1;
    repeat (4) @(posedge clk_sys);
    #1;
    $display("test faster clock done");
  endtask

  task automatic t_width;
    exact(32'h4011_8000, 1'b0, 2'h1, 7);
    exact(32'h4011_8000, 1'b1, 2'h1, 6);
    exact(32'h4011_8000, 1'b0, 2'h0, 5);
    exact(32'h4011_A000, 1'b0, 2'h2, 7);
    exact(32'h4011_A000, 1'b1, 2'h1, 4);
    $display("test width surcharge done");
  endtask

  task automatic t_link;
    int   n;
    logic e;
    busy_len = 8'h28;
    access(32'h6400_0010, 1'b0, 2'h2, n, e);
    check((n >= 40) && (n <= 43), 1'b1, "read stretched by link");
    busy_len = 8'h1E;
    access(32'h6400_0014, 1'b1, 2'h2, n, e);
    check((n >= 30) && (n <= 33), 1'b1, "write stretched by link");
    busy_len = 8'h0A;
    exact(32'h6400_0000, 1'b1, 2'h2, 14);
    busy_len = 8'h00;
    $display("test flash link done");
  endtask

  task automatic t_unmapped;
    int   n;
    logic e;
    // outside the internal I/O area: its reserved holes are off limits
    access(32'h3000_0000, 1'b0, 2'h2, n, e);
    check({n[7:0], e}, {8'h02, 1'b1}, "unmapped answer");
    access(32'h7000_0000, 1'b1, 2'h2, n, e);
    check({n[7:0], e}, {8'h02, 1'b1}, "unmapped answer");
    exact(32'h4000_0000, 1'b0, 2'h2, 2);
    $display("test unmapped done");
  endtask

  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #1;
    t_reset();
    @(posedge clk_sys);
    #1;
    t_equal();
    t_faster();
    t_width();
    t_link();
    t_unmapped();
    report_and_stop();
  end

  // whole run is well under 2000 cycles
  initial begin
    #(40 * 20000);
    miscompares++;
    report_and_stop();
  end
endmodule

// ===== pap_ce_div.sv
// one-cycle clock-enable divider for a peripheral or flash clock rate
`timescale 1ns/10ps
module pap_ce_div (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [3:0] div,
  output logic            ce
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] last;

  always_comb begin
    // a ratio of zero is treated as equal clocks
    last = (div == 4'h0) ? 4'h0 : 4'(div - 4'h1);
    ce = (cnt >= last);
    next_cnt = ce ? 4'h0 : 4'(cnt + 4'h1);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt <= pap_pkg::PAP_DIV_RESET;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ===== pap_pkg.sv
// constants for the peripheral access wait-state timer
package pap_pkg;

  localparam int PAP_NREG = 25;

  // cycle unit of each region
  localparam logic [1:0] PAP_UNIT_SYS   = 2'h0;
  localparam logic [1:0] PAP_UNIT_FAST  = 2'h1;
  localparam logic [1:0] PAP_UNIT_SLOW  = 2'h2;
  localparam logic [1:0] PAP_UNIT_FLASH = 2'h3;

  // access size codes
  localparam logic [1:0] PAP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] PAP_SIZE_HALF = 2'h1;
  localparam logic [1:0] PAP_SIZE_WORD = 2'h2;

  // region indices with a width-dependent surcharge
  localparam logic [4:0] PAP_IDX_SERIAL_IF  = 5'h0F;
  localparam logic [4:0] PAP_IDX_SERIAL_PER = 5'h10;
  localparam logic [5:0] PAP_WIDE_EXTRA     = 6'h02;

  // unmapped addresses answer after this many system cycles
  localparam logic [5:0] PAP_UNMAPPED_CYC = 6'h02;

  // divider reset value and ratio meaning equal clocks
  localparam logic [3:0] PAP_DIV_RESET = 4'h0;
  localparam logic [3:0] PAP_DIV_EQUAL = 4'h1;

  localparam logic [31:0] PAP_LO [PAP_NREG] = '{
    32'h4000_0000, 32'h4000_8000, 32'h4001_E000, 32'h4001_E400, 32'h4008_0000,
    32'h4008_2000, 32'h4008_4000, 32'h4008_A000, 32'h4009_0000, 32'h4009_4000,
    32'h4009_2000, 32'h400A_8000, 32'h400E_0000, 32'h400E_8000, 32'h4010_8000,
    32'h4011_8000, 32'h4011_A000, 32'h4016_1000, 32'h4016_9000, 32'h4017_0000,
    32'h6400_0000, 32'h6400_0010, 32'h6400_0014, 32'h6400_0804, 32'h407F_C000};
  localparam logic [31:0] PAP_HI [PAP_NREG] = '{
    32'h4000_6FFF, 32'h4001_CFFF, 32'h4001_E3FF, 32'h4001_E5FF, 32'h4008_0FFF,
    32'h4008_3FFF, 32'h4008_4FFF, 32'h4008_AFFF, 32'h4009_3FFF, 32'h4009_4FFF,
    32'h4009_FFFF, 32'h400A_9FFF, 32'h400E_0FFF, 32'h400E_8FFF, 32'h4010_9FFF,
    32'h4011_8FFF, 32'h4011_AFFF, 32'h4016_1FFF, 32'h4016_9FFF, 32'h4017_2FFF,
    32'h6400_000F, 32'h6400_0013, 32'h6400_0037, 32'h6400_0807, 32'h407F_EFFF};
  localparam logic [1:0] PAP_UNIT [PAP_NREG] = '{
    2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
  // counts with equal clocks
  localparam logic [4:0] PAP_RD_EQ [PAP_NREG] = '{
    5'h02, 5'h04, 5'h05, 5'h09, 5'h05, 5'h05, 5'h05, 5'h05, 5'h06, 5'h04, 5'h05,
    5'h05, 5'h05, 5'h07, 5'h05, 5'h05, 5'h05, 5'h06, 5'h07, 5'h05, 5'h05, 5'h19,
    5'h05, 5'h04, 5'h03};
  localparam logic [4:0] PAP_WR_EQ [PAP_NREG] = '{
    5'h02, 5'h03, 5'h04, 5'h08, 5'h04, 5'h04, 5'h04, 5'h04, 5'h05, 5'h03, 5'h04,
    5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h0E, 5'h06,
    5'h0E, 5'h03, 5'h03};
  // upper counts with the system clock faster than the unit clock
  localparam logic [4:0] PAP_RD_FAST [PAP_NREG] = '{
    5'h02, 5'h04, 5'h05, 5'h08, 5'h05, 5'h05, 5'h05, 5'h05, 5'h06, 5'h04, 5'h05,
    5'h05, 5'h05, 5'h07, 5'h05, 5'h05, 5'h05, 5'h06, 5'h07, 5'h05, 5'h05, 5'h19,
    5'h05, 5'h04, 5'h03};
  localparam logic [4:0] PAP_WR_FAST [PAP_NREG] = '{
    5'h02, 5'h03, 5'h04, 5'h08, 5'h04, 5'h04, 5'h04, 5'h04, 5'h05, 5'h03, 5'h04,
    5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h0E, 5'h05,
    5'h0E, 5'h03, 5'h03};
  // regions whose count is only a minimum, stretched by the flash link
  localparam logic [PAP_NREG-1:0] PAP_RD_OPEN = 25'h020_0000;
  localparam logic [PAP_NREG-1:0] PAP_WR_OPEN = 25'h070_0000;

endpackage

// ===== pap_qspi_link.sv
// model of the quad flash link: busy for a set span after each access to its range
`timescale 1ns/10ps
module pap_qspi_link (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        req_valid,
  input  wire logic        req_ready,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  busy_len,
  output logic             qspi_busy
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       hit;

  assign hit = (req_addr >= 32'h6400_0000) && (req_addr <= 32'h6400_0037);

  // link bus cycle starts with the taken access and runs busy_len cycles
  always_comb begin
    next_cnt = cnt;
    if (req_valid && req_ready && hit) begin
      next_cnt = busy_len;
    end else if (cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign qspi_busy = (cnt != 8'h00);
endmodule
